// File: src/host_port_select_reset_config.sv
/*
 * Host parallel port front end with bus style selection, register file with
 * defined reset values, and the serial port pin configuration it steers.
 * Assumes all host pins are asynchronous to mclk_in and held stable for well
 * over four clock cycles per strobe phase; protocol engine events arrive as
 * one-cycle set pulses on the same clock.
 */
`timescale 1ns/10ps

// How it works
// - Address-latch pin level picks strobe plus read/write or split strobes; edges pick multiplexed.
// - Any address-latch edge, rising or falling, switches to the multiplexed style at once.
// - Multiplexed style is kept until the next hardware reset.
// - On reset release the block idles with every register at its reset value.
// - During reset both strobe-capable pins drive low, every other output floats.
// - In non-multiplexed styles the serial receive and interface pins act as address bits.
// - Channel status resets to transmit queue writable, receive queue ready for sixteen octets.
// - Mode register resets to zero: automatic, one-octet address, external timer, receiver off.
// - Serial port config resets to zero: data line high, interface pin floating, loops off.
// - Received command/indicate register resets to channel busy, code all ones, no change.
// - Transmit command/indicate register resets to no bus request, code all ones, T and E set.
// - Terminal sync config resets to functions disabled, bus address zero, no sync transfer.
// - Frame fill config resets so idle time between frames carries continuous ones.
// - Interface mode config resets to port version one with both strobes low.
// - Receive byte counters reset to zero bytes received.
// - Clock-request bit pulls the first port data line low.
// - Timing-mode bit selects timing mode zero or one, or terminal versus non-terminal.
// - In version two the driver bit picks open-drain or push-pull data outputs.
// - In version two the strobe channel fields set strobe polarity and HDLC channel.
// - The interface-version bit selects version-one or version-two port operation.
// - Until the first serial config write both strobe pins stay low as strobes.
module host_port_select_reset_config (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic ale_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [5:0] addr_in,
  input wire logic [7:0] ad_in,
  output logic [7:0] ad_out,
  output logic ad_oe_out,
  input wire logic serial_receive_pin_in,
  input wire logic serial_interface_pin_in,
  output logic serial_interface_pin_out,
  output logic serial_interface_pin_oe_out,
  output logic port_data_line_one_out,
  output logic port_data_line_one_oe_out,
  output logic serial_tx_or_strobe_one_out,
  output logic serial_tx_or_strobe_one_oe_out,
  output logic clock_sync_or_strobe_two_out,
  output logic clock_sync_or_strobe_two_oe_out,
  input wire logic [7:0] interrupt_status_set_in,
  input wire logic [7:0] extended_interrupt_status_set_in,
  output logic command_pulse_out,
  output logic [7:0] command_code_out,
  output logic [1:0] bus_style_out,
  output logic timing_mode_out,
  output logic port_version_out,
  output logic [1:0] hdlc_channel_out
);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [host_port_pkg::PIN_W-1:0] pin_raw;
  logic [host_port_pkg::PIN_W-1:0] pin_s1_q;
  logic [host_port_pkg::PIN_W-1:0] pin_s2_q;
  logic [host_port_pkg::PIN_W-1:0] pin_s3_q;
  logic [host_port_pkg::PIN_W-1:0] pin_q;
  logic [2:0] warm_q;
  logic pins_valid_q;
  logic ale_prev_q;
  logic ale_edge;
  logic ale_fall;

  assign pin_raw = {ale_in, cs_n_in, rd_n_in, wr_n_in, serial_receive_pin_in,
                    serial_interface_pin_in, addr_in, ad_in};

  // Three stages; a bit is accepted only once stages two and three agree.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_q <= '0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < host_port_pkg::PIN_W; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  // The pin view is meaningless until the pipeline has filled after reset,
  // otherwise a high address-latch pin would look like an edge.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      warm_q <= 3'h0;
      pins_valid_q <= 1'b0;
      ale_prev_q <= 1'b0;
    end else begin
      ale_prev_q <= pin_q[host_port_pkg::PIN_ALE];
      if (warm_q != host_port_pkg::WARMUP_CYCLES) begin
        warm_q <= warm_q + 3'h1;
      end else begin
        pins_valid_q <= 1'b1;
      end
    end
  end

  assign ale_edge = pins_valid_q && (pin_q[host_port_pkg::PIN_ALE] != ale_prev_q);
  assign ale_fall = ale_edge && ale_prev_q;

  // ----------------------------------------------------------------
  // Bus style selection
  // ----------------------------------------------------------------
  host_port_pkg::bus_style_t style_q;
  logic is_mux;

  // Level decides until the first edge; after that the style is locked.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      style_q <= host_port_pkg::BUS_STROBE_RW;
    end else if (style_q == host_port_pkg::BUS_MUX) begin
      style_q <= host_port_pkg::BUS_MUX;
    end else if (ale_edge) begin
      style_q <= host_port_pkg::BUS_MUX;
    end else if (pins_valid_q) begin
      style_q <= pin_q[host_port_pkg::PIN_ALE] ? host_port_pkg::BUS_STROBE_RW
                                              : host_port_pkg::BUS_SPLIT;
    end
  end

  assign is_mux = (style_q == host_port_pkg::BUS_MUX);
  assign bus_style_out = style_q;

  // ----------------------------------------------------------------
  // Strobe and address decode
  // ----------------------------------------------------------------
  logic chip_sel;
  logic rd_act;
  logic wr_act;
  logic rd_act_q;
  logic wr_act_q;
  logic [5:0] mux_addr_q;
  logic [5:0] bus_addr;
  logic [5:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic wr_commit;
  logic rd_done;

  // In strobe plus read/write style the read pin carries the data strobe
  // and the write pin carries the read/write direction.
  always_comb begin
    chip_sel = pins_valid_q && !pin_q[host_port_pkg::PIN_CS_N];
    if (style_q == host_port_pkg::BUS_STROBE_RW) begin
      rd_act = chip_sel && !pin_q[host_port_pkg::PIN_RD_N] && pin_q[host_port_pkg::PIN_WR_N];
      wr_act = chip_sel && !pin_q[host_port_pkg::PIN_RD_N] && !pin_q[host_port_pkg::PIN_WR_N];
    end else begin
      rd_act = chip_sel && !pin_q[host_port_pkg::PIN_RD_N];
      wr_act = chip_sel && !pin_q[host_port_pkg::PIN_WR_N];
    end
  end

  // Address bits two and five borrow the serial receive and interface pins.
  always_comb begin
    if (is_mux) begin
      bus_addr = mux_addr_q;
    end else begin
      bus_addr = {pin_q[host_port_pkg::PIN_SIP], pin_q[host_port_pkg::PIN_ADDR+4],
                  pin_q[host_port_pkg::PIN_ADDR+3], pin_q[host_port_pkg::PIN_SERIAL_RECEIVE_PIN],
                  pin_q[host_port_pkg::PIN_ADDR+1], pin_q[host_port_pkg::PIN_ADDR]};
    end
  end

  // Multiplexed address is captured as the latch strobe falls.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mux_addr_q <= 6'h00;
    end else if (ale_fall) begin
      mux_addr_q <= pin_q[host_port_pkg::PIN_AD +: 6];
    end
  end

  // Writes take effect at the trailing edge of the write strobe, using the
  // data seen while the strobe was active, so a slow data bus is tolerated.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      wr_addr_q <= 6'h00;
      wr_data_q <= host_port_pkg::RST_ZERO;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      if (wr_act) begin
        wr_addr_q <= bus_addr;
        wr_data_q <= pin_q[host_port_pkg::PIN_AD +: 8];
      end
    end
  end

  assign wr_commit = wr_act_q && !wr_act;
  assign rd_done = rd_act_q && !rd_act;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:1] interrupt_status_q;
  logic [7:0] mask_q;
  logic [7:0] extended_interrupt_status_q;
  logic [7:0] channel_status_flags_q;
  logic [7:0] mode_q;
  logic [7:0] rx_byte_count_low_q;
  logic [7:0] rx_byte_count_high_q;
  logic [7:0] serial_port_config_q;
  logic [7:0] cirr_q;
  logic [7:0] cixr_q;
  logic [7:0] terminal_sync_config_q;
  logic [7:0] frame_fill_config_q;
  logic [7:0] interface_mode_config_q;
  logic serial_port_config_written_q;
  logic [7:0] rd_addr_q;
  logic clr_interrupt_status;
  logic clr_extended_interrupt_status;

  // Status-like registers start at their documented idle values and are
  // only read by the host here; the protocol engine owns their updates.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      channel_status_flags_q <= host_port_pkg::RST_CHANNEL_STATUS_FLAGS;
      rx_byte_count_low_q <= host_port_pkg::RST_ZERO;
      rx_byte_count_high_q <= host_port_pkg::RST_ZERO;
      cirr_q <= host_port_pkg::RST_CIRR;
    end else begin
      channel_status_flags_q <= channel_status_flags_q;
      rx_byte_count_low_q <= rx_byte_count_low_q;
      rx_byte_count_high_q <= rx_byte_count_high_q;
      cirr_q <= cirr_q;
    end
  end

  // Host-writable configuration; every reset value is the idle setting.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mask_q <= host_port_pkg::RST_ZERO;
      mode_q <= host_port_pkg::RST_ZERO;
      serial_port_config_q <= host_port_pkg::RST_ZERO;
      cixr_q <= host_port_pkg::RST_CIXR;
      terminal_sync_config_q <= host_port_pkg::RST_ZERO;
      frame_fill_config_q <= host_port_pkg::RST_ZERO;
      interface_mode_config_q <= host_port_pkg::RST_ZERO;
      serial_port_config_written_q <= 1'b0;
    end else if (wr_commit) begin
      case (wr_addr_q)
        host_port_pkg::OFF_MASK: mask_q <= wr_data_q;
        host_port_pkg::OFF_MODE: mode_q <= wr_data_q;
        host_port_pkg::OFF_SERIAL_PORT_CONFIG: begin
          serial_port_config_q <= wr_data_q;
          serial_port_config_written_q <= 1'b1;
        end
        host_port_pkg::OFF_CIXR: cixr_q <= wr_data_q;
        host_port_pkg::OFF_TERMINAL_SYNC_CONFIG: terminal_sync_config_q <= wr_data_q;
        host_port_pkg::OFF_FRAME_FILL_CONFIG: frame_fill_config_q <= wr_data_q;
        host_port_pkg::OFF_INTERFACE_MODE_CONFIG: interface_mode_config_q <= wr_data_q;
        default: mask_q <= mask_q;
      endcase
    end
  end

  // Command writes leave a one-cycle pulse and the last code written.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      command_pulse_out <= 1'b0;
      command_code_out <= host_port_pkg::RST_ZERO;
    end else begin
      command_pulse_out <= wr_commit && (wr_addr_q == host_port_pkg::OFF_COMMAND_STROBE);
      if (wr_commit && (wr_addr_q == host_port_pkg::OFF_COMMAND_STROBE)) begin
        command_code_out <= wr_data_q;
      end
    end
  end

  // Reads clear at the end of the strobe so a long strobe clears once.
  // A set arriving in the clearing cycle survives the clear.
  assign clr_interrupt_status = rd_done && (rd_addr_q[5:0] == host_port_pkg::OFF_INTERRUPT_STATUS);
  assign clr_extended_interrupt_status = rd_done && (rd_addr_q[5:0] == host_port_pkg::OFF_EXTENDED_INTERRUPT_STATUS);

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      interrupt_status_q <= 7'h00;
      extended_interrupt_status_q <= host_port_pkg::RST_ZERO;
      rd_addr_q <= host_port_pkg::RST_ZERO;
    end else begin
      if (rd_act) begin
        rd_addr_q <= {2'b00, bus_addr};
      end
      interrupt_status_q <= (clr_interrupt_status ? (interrupt_status_q & mask_q[7:1]) : interrupt_status_q) | interrupt_status_set_in[7:1];
      extended_interrupt_status_q <= (clr_extended_interrupt_status ? host_port_pkg::RST_ZERO : extended_interrupt_status_q) | extended_interrupt_status_set_in;
    end
  end

  // Read data is registered while the read strobe is active.
  logic [7:0] rd_mux;

  always_comb begin
    case (bus_addr)
      host_port_pkg::OFF_INTERRUPT_STATUS: rd_mux = {interrupt_status_q, |extended_interrupt_status_q} & ~mask_q;
      host_port_pkg::OFF_MASK: rd_mux = mask_q;
      host_port_pkg::OFF_CHANNEL_STATUS_FLAGS: rd_mux = channel_status_flags_q;
      host_port_pkg::OFF_MODE: rd_mux = mode_q;
      host_port_pkg::OFF_EXTENDED_INTERRUPT_STATUS: rd_mux = extended_interrupt_status_q;
      host_port_pkg::OFF_RX_BYTE_COUNT_LOW: rd_mux = rx_byte_count_low_q;
      host_port_pkg::OFF_RX_BYTE_COUNT_HIGH: rd_mux = rx_byte_count_high_q;
      host_port_pkg::OFF_SERIAL_PORT_CONFIG: rd_mux = serial_port_config_q;
      host_port_pkg::OFF_CIRR: rd_mux = cirr_q;
      host_port_pkg::OFF_CIXR: rd_mux = cixr_q;
      host_port_pkg::OFF_TERMINAL_SYNC_CONFIG: rd_mux = terminal_sync_config_q;
      host_port_pkg::OFF_FRAME_FILL_CONFIG: rd_mux = frame_fill_config_q;
      host_port_pkg::OFF_INTERFACE_MODE_CONFIG: rd_mux = interface_mode_config_q;
      host_port_pkg::OFF_PSTAT: rd_mux = {5'h00, serial_port_config_written_q, style_q};
      default: rd_mux = host_port_pkg::RST_ZERO;
    endcase
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ad_out <= host_port_pkg::RST_ZERO;
    end else if (rd_act) begin
      ad_out <= rd_mux;
    end
  end

  assign ad_oe_out = rd_act_q && rd_act;

  // ----------------------------------------------------------------
  // Serial port pin configuration
  // ----------------------------------------------------------------
  logic version_two;
  logic strobe_one_pol;
  logic strobe_two_pol;

  assign version_two = interface_mode_config_q[host_port_pkg::INTERFACE_MODE_CONFIG_VERSION];
  assign port_version_out = version_two;
  assign timing_mode_out = serial_port_config_q[host_port_pkg::SERIAL_PORT_CONFIG_TIMING];
  assign strobe_one_pol = interface_mode_config_q[host_port_pkg::INTERFACE_MODE_CONFIG_STROBE1_HI];
  assign strobe_two_pol = interface_mode_config_q[host_port_pkg::INTERFACE_MODE_CONFIG_STROBE2_HI];
  assign hdlc_channel_out = interface_mode_config_q[1:0];

  // Pin drivers are flops, so reset puts them straight into the reset
  // pattern without any dependence on the configuration registers.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      serial_tx_or_strobe_one_out <= 1'b0;
      serial_tx_or_strobe_one_oe_out <= 1'b1;
      clock_sync_or_strobe_two_out <= 1'b0;
      clock_sync_or_strobe_two_oe_out <= 1'b1;
      port_data_line_one_out <= 1'b0;
      port_data_line_one_oe_out <= 1'b0;
      serial_interface_pin_out <= 1'b0;
      serial_interface_pin_oe_out <= 1'b0;
    end else begin
      serial_tx_or_strobe_one_oe_out <= 1'b1;
      clock_sync_or_strobe_two_oe_out <= 1'b1;
      if (!serial_port_config_written_q) begin
        serial_tx_or_strobe_one_out <= 1'b0;
        clock_sync_or_strobe_two_out <= 1'b0;
      end else if (version_two) begin
        serial_tx_or_strobe_one_out <= strobe_one_pol;
        clock_sync_or_strobe_two_out <= strobe_two_pol;
      end else begin
        // Idle serial output carries ones fill unless flag fill is chosen.
        serial_tx_or_strobe_one_out <= !frame_fill_config_q[host_port_pkg::FRAME_FILL_CONFIG_FILL];
        clock_sync_or_strobe_two_out <= 1'b0;
      end
      // Clock request wins over the driver style so the layer one device
      // always sees the request.
      if (serial_port_config_q[host_port_pkg::SERIAL_PORT_CONFIG_PULLDOWN]) begin
        port_data_line_one_out <= 1'b0;
        port_data_line_one_oe_out <= 1'b1;
      end else begin
        port_data_line_one_out <= 1'b1;
        port_data_line_one_oe_out <= version_two && interface_mode_config_q[host_port_pkg::INTERFACE_MODE_CONFIG_DRIVER];
      end
      // The interface pin only drives in multiplexed style; otherwise it is
      // an address input.
      serial_interface_pin_out <= 1'b1;
      serial_interface_pin_oe_out <= is_mux && serial_port_config_q[host_port_pkg::SERIAL_PORT_CONFIG_PORT_ACT];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic first_q;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  a_mux_sticky: assert property (is_mux |=> is_mux [*8])
    else $error("multiplexed style was left without reset");
  a_edge_to_mux: assert property (ale_edge |=> is_mux)
    else $error("address-latch edge did not select multiplexed style");
  a_level_style: assert property (!is_mux && pins_valid_q && !ale_edge
      |=> style_q == ($past(pin_q[host_port_pkg::PIN_ALE]) ? host_port_pkg::BUS_STROBE_RW
                                                          : host_port_pkg::BUS_SPLIT))
    else $error("level-selected bus style wrong");
  a_reset_values: assert property (first_q |-> channel_status_flags_q == 8'h48 && cirr_q == 8'h7C
      && cixr_q == 8'hBF && serial_port_config_q == 8'h00 && mode_q == 8'h00 && interface_mode_config_q == 8'h00)
    else $error("register reset value wrong");
  a_strobe_prewrite: assert property (!serial_port_config_written_q |=> !serial_tx_or_strobe_one_out
      && !clock_sync_or_strobe_two_out && serial_tx_or_strobe_one_oe_out)
    else $error("strobe pins not low before first serial config write");
  a_clock_request: assert property (serial_port_config_q[host_port_pkg::SERIAL_PORT_CONFIG_PULLDOWN]
      |=> port_data_line_one_oe_out && !port_data_line_one_out)
    else $error("clock request did not pull data line low");
  a_addr_pin_float: assert property (!is_mux |=> !serial_interface_pin_oe_out)
    else $error("interface pin driven while used as address");
  a_strobe_polarity: assert property (serial_port_config_written_q && version_two
      |=> serial_tx_or_strobe_one_out == $past(strobe_one_pol))
    else $error("strobe one level does not follow polarity");
  a_mux_latch: assert property (ale_fall |=> mux_addr_q == $past(pin_q[5:0]))
    else $error("multiplexed address not latched at strobe fall");

  c_mux_entry: cover property (!is_mux ##1 is_mux);
  c_serial_port_config_write: cover property (!serial_port_config_written_q ##1 serial_port_config_written_q);
  c_interrupt_status_clear: cover property (clr_interrupt_status);
  c_command: cover property (command_pulse_out);

endmodule

// File: src/host_port_pkg.sv
/*
 * Shared constants and types of the host port front end: register offsets,
 * reset values, field positions, bus styles and pin synchroniser layout.
 * Assumes a single 100 MHz clock domain and an 8-bit host data path.
 */
package host_port_pkg;

  // ----------------------------------------------------------------
  // Host bus styles
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_STROBE_RW = 2'b00,
    BUS_SPLIT = 2'b01,
    BUS_MUX = 2'b10
  } bus_style_t;

  // ----------------------------------------------------------------
  // Register offsets on the 6-bit host address
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_INTERRUPT_STATUS = 6'h20;
  localparam logic [5:0] OFF_MASK = 6'h21;
  localparam logic [5:0] OFF_CHANNEL_STATUS_FLAGS = 6'h22;
  localparam logic [5:0] OFF_COMMAND_STROBE = 6'h23;
  localparam logic [5:0] OFF_MODE = 6'h24;
  localparam logic [5:0] OFF_EXTENDED_INTERRUPT_STATUS = 6'h25;
  localparam logic [5:0] OFF_RX_BYTE_COUNT_LOW = 6'h26;
  localparam logic [5:0] OFF_RX_BYTE_COUNT_HIGH = 6'h27;
  localparam logic [5:0] OFF_SERIAL_PORT_CONFIG = 6'h28;
  localparam logic [5:0] OFF_CIRR = 6'h29;
  localparam logic [5:0] OFF_CIXR = 6'h2A;
  localparam logic [5:0] OFF_TERMINAL_SYNC_CONFIG = 6'h2B;
  localparam logic [5:0] OFF_FRAME_FILL_CONFIG = 6'h2C;
  localparam logic [5:0] OFF_INTERFACE_MODE_CONFIG = 6'h2D;
  localparam logic [5:0] OFF_PSTAT = 6'h2E;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CHANNEL_STATUS_FLAGS = 8'h48;
  localparam logic [7:0] RST_CIRR = 8'h7C;
  localparam logic [7:0] RST_CIXR = 8'hBF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SERIAL_PORT_CONFIG_PULLDOWN = 7;
  localparam int SERIAL_PORT_CONFIG_PORT_ACT = 6;
  localparam int SERIAL_PORT_CONFIG_TIMING = 5;
  localparam int SERIAL_PORT_CONFIG_TEST_LOOP = 4;
  localparam int INTERFACE_MODE_CONFIG_VERSION = 7;
  localparam int INTERFACE_MODE_CONFIG_STROBE2_HI = 6;
  localparam int INTERFACE_MODE_CONFIG_DRIVER = 3;
  localparam int INTERFACE_MODE_CONFIG_STROBE1_HI = 2;
  localparam int FRAME_FILL_CONFIG_FILL = 0;
  localparam int INTERRUPT_STATUS_EXT = 0;

  // ----------------------------------------------------------------
  // Synchronised pin vector layout and warm-up count
  // ----------------------------------------------------------------
  localparam int PIN_W = 20;
  localparam int PIN_ALE = 19;
  localparam int PIN_CS_N = 18;
  localparam int PIN_RD_N = 17;
  localparam int PIN_WR_N = 16;
  localparam int PIN_SERIAL_RECEIVE_PIN = 15;
  localparam int PIN_SIP = 14;
  localparam int PIN_ADDR = 8;
  localparam int PIN_AD = 0;
  localparam logic [2:0] WARMUP_CYCLES = 3'h5;

endpackage

// File: dv/host_bus_model.sv
/* Host processor model that drives the parallel port pins.
   Assumes a free running clock on clk_in and that mux_in changes between accesses. */
`timescale 1ns/10ps
// ----
// Host bus model
// ----
module host_bus_model (
  input wire logic clk_in,
  input wire logic mux_in,
  input wire logic ds_in, // High selects the data strobe plus read/write style.
  input wire logic [7:0] rdata_in,
  output logic ale_out = 1'b0,
  output logic cs_n_out = 1'b1,
  output logic rd_n_out = 1'b1,
  output logic wr_n_out = 1'b1,
  output logic [5:0] addr_out = 6'h00,
  output logic [7:0] ad_out = 8'h00,
  output logic a2_out = 1'b0,
  output logic a5_out = 1'b0
);
  // One access; each phase lasts eight clocks, above the five that the port needs.
  task automatic acc(input logic we, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk_in);
    if (mux_in) begin
      ale_out <= 1'b1;
      ad_out <= {2'h0, a};
      repeat (8) @(posedge clk_in);
      ale_out <= 1'b0;
      repeat (8) @(posedge clk_in);
    end
    cs_n_out <= 1'b0;
    addr_out <= a ^ 6'h24; // Bits 2 and 5 are wrong here, so only the serial pins carry them.
    a2_out <= a[2];
    a5_out <= a[5];
    ad_out <= we ? d : ~d;
    rd_n_out <= we & ~ds_in; // A data strobe is asserted for writes as well.
    wr_n_out <= ~we;
    repeat (8) @(posedge clk_in);
    q = rdata_in;
    cs_n_out <= 1'b1;
    rd_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    ad_out <= ~ad_out; // Released lines must not keep showing old data.
  endtask
endmodule

// File: dv/host_port_select_reset_config_tb_top.sv
/* Bench: reset values, pin states, programming, interrupts and mux style.
   Assumes the host model is compiled first. */
`timescale 1ns/10ps
// ----
// Bench top
// ----
module host_port_select_reset_config_tb_top;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic ale_lvl = 1'b0;
  logic mux = 1'b0;
  logic [7:0] interrupt_status_set = 8'h00;
  logic [7:0] extended_interrupt_status_set = 8'h00;
  logic ale, cs_n, rd_n, wr_n, a2, a5, sip_o, sip_oe, ad_oe, s1, s1oe, s2, s2oe, d1, d1oe, tm, pv;
  logic [5:0] addr;
  logic [7:0] ad_h, ad_o, q, r, cmd;
  logic [1:0] style, hch;
  logic cmd_p;
  int n_cmd = 0;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 32'h49168DBC;
  host_bus_model u_host (.clk_in(mclk_in), .mux_in(mux), .ds_in(ale_lvl), .ale_out(ale),
    .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .addr_out(addr), .ad_out(ad_h),
    .a2_out(a2), .a5_out(a5), .rdata_in(ad_oe ? ad_o : ad_h));
  host_port_select_reset_config u_dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .ale_in(ale | ale_lvl), .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .addr_in(addr),
    .ad_in(ad_oe ? ad_o : ad_h), .ad_out(ad_o), .ad_oe_out(ad_oe), .serial_receive_pin_in(a2),
    .serial_interface_pin_in(sip_oe ? sip_o : a5), .serial_interface_pin_out(sip_o),
    .serial_interface_pin_oe_out(sip_oe), .port_data_line_one_out(d1),
    .port_data_line_one_oe_out(d1oe), .serial_tx_or_strobe_one_out(s1),
    .serial_tx_or_strobe_one_oe_out(s1oe), .clock_sync_or_strobe_two_out(s2),
    .clock_sync_or_strobe_two_oe_out(s2oe), .interrupt_status_set_in(interrupt_status_set), .extended_interrupt_status_set_in(extended_interrupt_status_set),
    .command_pulse_out(cmd_p), .command_code_out(cmd), .bus_style_out(style),
    .timing_mode_out(tm), .port_version_out(pv), .hdlc_channel_out(hch));
  always #5 mclk_in = ~mclk_in;
  // Count command pulses; a pulse stuck high shows up as a large count.
  always @(posedge mclk_in) begin
    if (cmd_p === 1'b1) begin
      n_cmd++;
    end
  end
  // Cut a hang short; the run needs about six hundred clocks.
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc > 8000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    u_host.acc(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_host.acc(1'b1, a, d, q);
  endtask
  // Value after reset; the own status place shows the split style.
  function automatic logic [7:0] rv(input logic [5:0] a);
    case (a)
      6'h22: return 8'h48;
      6'h29: return 8'h7C;
      6'h2A: return 8'hBF;
      6'h2E: return 8'h01;
      default: return 8'h00;
    endcase
  endfunction
  task automatic do_reset(input logic lvl);
    reset_n_in <= 1'b0;
    ale_lvl <= lvl;
    repeat (5) @(posedge mclk_in);
    chk({1'b0, s1, s1oe, s2, s2oe, d1oe, sip_oe, ad_oe}, 8'h28);
    repeat (5) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    repeat (12) @(posedge mclk_in);
    chk({6'h00, style}, {7'h00, ~lvl});
  endtask
  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence; a second reset proves that the mux style is left only that way.
  initial begin
    do_reset(1'b0);
    chk({5'h00, s1, s2, s1oe}, 8'h01);
    for (int a = 6'h1F; a <= 6'h2E; a++) begin
      rd(a[5:0], rv(a[5:0]));
    end
    wr(6'h28, 8'hA0);
    chk({4'h0, s1, d1, d1oe, tm}, 8'h0B);
    rd(6'h2E, 8'h05);
    r = 8'($random(seed));
    wr(6'h2D, r | 8'h80);
    wr(6'h28, 8'h00);
    chk({4'h0, pv, hch, tm}, {4'h0, 1'b1, r[1:0], 1'b0});
    chk({7'h00, d1oe}, {7'h00, r[3]});
    chk({6'h00, s1, s2}, {6'h00, r[2], r[6]});
    r = 8'($random(seed)) | 8'h01;
    @(posedge mclk_in);
    extended_interrupt_status_set <= r;
    interrupt_status_set <= 8'h80;
    @(posedge mclk_in);
    extended_interrupt_status_set <= 8'h00;
    interrupt_status_set <= 8'h00;
    rd(6'h20, 8'h81);
    rd(6'h25, r);
    rd(6'h20, 8'h00);
    wr(6'h23, r);
    chk(cmd, r);
    chk(8'(n_cmd), 8'h01);
    mux <= 1'b1;
    r = 8'($random(seed));
    wr(6'h21, r);
    chk({6'h00, style}, 8'h02);
    rd(6'h21, r);
    wr(6'h28, 8'h40);
    chk({6'h00, sip_o, sip_oe}, 8'h03);
    mux <= 1'b0;
    repeat (20) @(posedge mclk_in);
    chk({6'h00, style}, 8'h02);
    do_reset(1'b1);
    rd(6'h21, 8'h00);
    wr(6'h21, r);
    rd(6'h21, r);
    complete_run();
  end
endmodule
